// file: src/acr_defs.svh
// Timing and pin-level constants for the converter readout host controller
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

// ============================================================
// Clock and cycle arithmetic
`define ACR_CLK_PERIOD_NS   5
`define ACR_SYNC_STAGES     2
`define ACR_TMR_W           9
`define ACR_CYC_MIN(ns)     ((((ns) + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS) > 0 ? \
                             (((ns) + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS) : 1)
`define ACR_MAX(a, b)       (((a) > (b)) ? (a) : (b))
`define ACR_LOAD(ns)        9'(`ACR_CYC_MIN(ns) - 1)

// ============================================================
// Pin timing in ns (0.4 us and 1.52 us kept as ns figures)
`define ACR_T_CS_SETUP_NS   20
`define ACR_T_TRIG_LOW_NS   40
`define ACR_T_TRIG_HIGH_NS  20
`define ACR_T_BUS_QUIET_NS  40
`define ACR_T_BUSY_RISE_NS  45
`define ACR_T_CONV_NS       1520
`define ACR_T_BUSY_FALL_NS  20
`define ACR_T_ACQ_NS        400
`define ACR_T_MSB_VALID_NS  30
`define ACR_T_RD_LOW_NS     50
`define ACR_T_RD_HIGH_NS    20
`define ACR_T_CS_HIGH_NS    20
`define ACR_T_LAST_RD_NS    125
`define ACR_T_SEL_SETUP_NS  10
`define ACR_T_SEL_SPACE_NS  50
`define ACR_T_SYNC_NS       (`ACR_SYNC_STAGES * `ACR_CLK_PERIOD_NS)

// ============================================================
// Derived counts
`define ACR_ACQ_CYC         9'(`ACR_CYC_MIN(`ACR_T_ACQ_NS))
`define ACR_RISE_LIMIT_NS   (`ACR_T_BUSY_RISE_NS + `ACR_T_SYNC_NS)
`define ACR_CONV_LIMIT_NS   (`ACR_T_CONV_NS + `ACR_T_BUSY_FALL_NS + `ACR_T_SYNC_NS)
`define ACR_TRIG_HOLD_NS    `ACR_MAX(`ACR_T_TRIG_LOW_NS, `ACR_T_BUS_QUIET_NS)
`define ACR_RD_GAP_NS       `ACR_MAX(`ACR_T_RD_HIGH_NS, `ACR_T_SEL_SPACE_NS)
`define ACR_RECOVER_NS      `ACR_MAX(`ACR_T_LAST_RD_NS, `ACR_T_CS_HIGH_NS)

// ============================================================
// Data bus and select levels
`define ACR_DATA_W          18
`define ACR_HALF_W          16
`define ACR_TAIL_W          2
`define ACR_WIDTH_FULL      1'b1
`define ACR_WIDTH_HALF      1'b0
`define ACR_LANE_UPPER      1'b0
`define ACR_LANE_LOWER      1'b1
`define ACR_READS_FULL      2'h1
`define ACR_READS_HALF      2'h2

`endif

// file: src/acr_pkg.sv
// Types and read-plan functions for the converter readout host controller
`include "acr_defs.svh"
`default_nettype none

package acr_pkg;

    // ============================================================
    // Types
    typedef enum logic
    {
        ACR_MODE_FULL = 1'b0,
        ACR_MODE_HALF = 1'b1
    } acr_mode_e;

    typedef enum logic [3:0]
    {
        ACR_ST_IDLE    = 4'h0,
        ACR_ST_SELECT  = 4'h1,
        ACR_ST_TRIG    = 4'h3,
        ACR_ST_WAIT_HI = 4'h2,
        ACR_ST_WAIT_LO = 4'h6,
        ACR_ST_MSB     = 4'h7,
        ACR_ST_RD_LOW  = 4'h5,
        ACR_ST_RD_HIGH = 4'h4,
        ACR_ST_RECOVER = 4'hC
    } acr_state_e;

    typedef struct packed
    {
        logic conversion_trigger_n;
        logic select_n;
        logic read_n;
        logic lane_select;
        logic word_width_select;
    } acr_pins_s;

    typedef struct packed
    {
        logic                   valid;
        logic [`ACR_DATA_W-1:0] data;
    } acr_result_s;

    // ============================================================
    // Read plan
    function automatic logic acr_last(input acr_mode_e mode, input logic [1:0] idx);
        logic [1:0] reads;
        reads = (mode == ACR_MODE_FULL) ? `ACR_READS_FULL : `ACR_READS_HALF;
        return idx == 2'(reads - 2'h1);
    endfunction : acr_last

    function automatic logic acr_lane(input acr_mode_e mode, input logic [1:0] idx);
        return (mode == ACR_MODE_HALF && idx != 2'h0) ? `ACR_LANE_LOWER : `ACR_LANE_UPPER;
    endfunction : acr_lane

    function automatic logic acr_width(input acr_mode_e mode);
        return (mode == ACR_MODE_FULL) ? `ACR_WIDTH_FULL : `ACR_WIDTH_HALF;
    endfunction : acr_width

    // Full mode takes the whole bus; half mode takes the upper 16 bits then the tail
    function automatic logic [`ACR_DATA_W-1:0] acr_merge(
        input acr_mode_e              mode,
        input logic [1:0]             idx,
        input logic [`ACR_DATA_W-1:0] acc,
        input logic [`ACR_DATA_W-1:0] bus
    );
        logic [`ACR_DATA_W-1:0] res;
        res = acc;
        if (mode == ACR_MODE_FULL)
        begin
            res = bus;
        end
        else if (idx == 2'h0)
        begin
            res = {bus[`ACR_HALF_W-1:0], {`ACR_TAIL_W{1'b0}}};
        end
        else
        begin
            res = {acc[`ACR_DATA_W-1:`ACR_TAIL_W], bus[`ACR_TAIL_W-1:0]};
        end
        return res;
    endfunction : acr_merge

endpackage : acr_pkg

`default_nettype wire

// file: src/acr_interval_timer.sv
// Down-counting interval timer used for every pin interval of the controller except the acquisition window
`include "acr_defs.svh"
`default_nettype none

module acr_interval_timer
    import acr_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  load,
    input  wire logic [`ACR_TMR_W-1:0] load_value,
    output logic                       expired
);

    logic [`ACR_TMR_W-1:0] count_q;
    logic [`ACR_TMR_W-1:0] count_d;
    wire  logic            running;

    // ============================================================
    // Count
    // Loaded with N-1 on the edge a state is entered, so that state lasts N cycles
    assign running = (count_q != '0);
    assign expired = ~running;
    assign count_d = load ? load_value : (running ? count_q - 9'h001 : count_q);

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            count_q <= '0;
        end
        else
        begin
            count_q <= count_d;
        end
    end

endmodule : acr_interval_timer

`default_nettype wire

// file: src/acr_host_ctrl.sv
// Host controller that starts conversions and reads results over the converter pins
`include "acr_defs.svh"
`default_nettype none

module acr_host_ctrl
    import acr_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   start_valid,
    input  wire acr_mode_e              start_mode,
    output logic                        start_ready,
    output acr_result_s                 result,
    output logic                        conv_fault,
    output acr_pins_s                   pins,
    input  wire logic                   busy,
    input  wire logic [`ACR_DATA_W-1:0] data_bus
);

    // ============================================================
    // Declarations
    acr_state_e             state_q;
    acr_state_e             state_d;
    acr_mode_e              mode_q;
    acr_mode_e              mode_d;
    acr_pins_s              pins_q;
    acr_pins_s              pins_d;
    acr_result_s            result_q;
    acr_result_s            result_d;
    logic [1:0]             idx_q;
    logic [1:0]             idx_d;
    logic [`ACR_DATA_W-1:0] acc_q;
    logic [`ACR_DATA_W-1:0] acc_d;
    logic                   fault_q;
    logic                   fault_d;
    logic                   busy_meta_q;
    logic                   busy_s_q;
    logic [`ACR_DATA_W-1:0] data_meta_q;
    logic [`ACR_DATA_W-1:0] data_s_q;
    logic [`ACR_TMR_W-1:0]  acq_cnt_q;
    logic [`ACR_TMR_W-1:0]  acq_cnt_d;
    logic                   tmr_load;
    logic [`ACR_TMR_W-1:0]  tmr_value;
    logic                   tmr_expired;

    wire  logic             acq_ok;
    wire  logic             is_idle;
    wire  logic             last_read;
    wire  logic             next_lane;
    wire  logic             lane_moves;
    wire  logic [`ACR_DATA_W-1:0] merged;

    // ============================================================
    // Pin input synchronisers
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            busy_meta_q <= 1'b0;
            busy_s_q    <= 1'b0;
            data_meta_q <= '0;
            data_s_q    <= '0;
        end
        else
        begin
            busy_meta_q <= busy;
            busy_s_q    <= busy_meta_q;
            data_meta_q <= data_bus;
            data_s_q    <= data_meta_q;
        end
    end

    // ============================================================
    // Acquisition window: busy must be seen low long enough before a new trigger
    assign acq_cnt_d = busy_s_q ? '0 :
                       (acq_ok ? acq_cnt_q : acq_cnt_q + 9'h001);
    assign acq_ok    = (acq_cnt_q == `ACR_ACQ_CYC);

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            acq_cnt_q <= '0;
        end
        else
        begin
            acq_cnt_q <= acq_cnt_d;
        end
    end

    // ============================================================
    // Decode
    assign is_idle     = (state_q == ACR_ST_IDLE);
    assign start_ready = is_idle & acq_ok;
    assign last_read   = acr_last(mode_q, idx_q);
    assign next_lane   = acr_lane(mode_q, 2'(idx_q + 2'h1));
    assign lane_moves  = (next_lane != pins_q.lane_select);
    assign merged      = acr_merge(mode_q, idx_q, acc_q, data_s_q);

    // ============================================================
    // Interval timer
    acr_interval_timer u_timer
    (
        .clk        (clk),
        .reset_n    (reset_n),
        .load       (tmr_load),
        .load_value (tmr_value),
        .expired    (tmr_expired)
    );

    // ============================================================
    // Sequencer
    // Every interval is a whole count of cycles, rounded up; nothing assumes the
    // conversion time, the controller always waits on the synchronised busy
    always_comb
    begin
        state_d   = state_q;
        mode_d    = mode_q;
        pins_d    = pins_q;
        idx_d     = idx_q;
        acc_d     = acc_q;
        result_d  = '{valid: 1'b0, data: result_q.data};
        fault_d   = 1'b0;
        tmr_load  = 1'b0;
        tmr_value = '0;
        case (state_q)
            ACR_ST_IDLE:
            begin
                if (start_valid && acq_ok)
                begin
                    state_d                  = ACR_ST_SELECT;
                    mode_d                   = start_mode;
                    idx_d                    = 2'h0;
                    acc_d                    = '0;
                    pins_d.select_n          = 1'b0;
                    // Selects move together here, long after the previous frame ended
                    pins_d.lane_select       = acr_lane(start_mode, 2'h0);
                    pins_d.word_width_select = acr_width(start_mode);
                    tmr_load                 = 1'b1;
                    tmr_value                = `ACR_LOAD(`ACR_T_CS_SETUP_NS);
                end
            end
            ACR_ST_SELECT:
            begin
                if (tmr_expired)
                begin
                    state_d                     = ACR_ST_TRIG;
                    pins_d.conversion_trigger_n = 1'b0;
                    tmr_load                    = 1'b1;
                    tmr_value                   = `ACR_LOAD(`ACR_TRIG_HOLD_NS);
                end
            end
            ACR_ST_TRIG:
            begin
                if (tmr_expired)
                begin
                    state_d                     = ACR_ST_WAIT_HI;
                    pins_d.conversion_trigger_n = 1'b1;
                    tmr_load                    = 1'b1;
                    tmr_value                   = `ACR_LOAD(`ACR_RISE_LIMIT_NS);
                end
            end
            ACR_ST_WAIT_HI:
            begin
                if (busy_s_q)
                begin
                    state_d   = ACR_ST_WAIT_LO;
                    tmr_load  = 1'b1;
                    tmr_value = `ACR_LOAD(`ACR_CONV_LIMIT_NS);
                end
                else if (tmr_expired)
                begin
                    state_d         = ACR_ST_RECOVER;
                    fault_d         = 1'b1;
                    pins_d.select_n = 1'b1;
                    tmr_load        = 1'b1;
                    tmr_value       = `ACR_LOAD(`ACR_RECOVER_NS);
                end
            end
            ACR_ST_WAIT_LO:
            begin
                if (!busy_s_q)
                begin
                    state_d   = ACR_ST_MSB;
                    tmr_load  = 1'b1;
                    tmr_value = `ACR_LOAD(`ACR_T_MSB_VALID_NS);
                end
                else if (tmr_expired)
                begin
                    // A device stuck busy is reported rather than read
                    state_d         = ACR_ST_RECOVER;
                    fault_d         = 1'b1;
                    pins_d.select_n = 1'b1;
                    tmr_load        = 1'b1;
                    tmr_value       = `ACR_LOAD(`ACR_RECOVER_NS);
                end
            end
            ACR_ST_MSB:
            begin
                // Trigger fell long ago, so the quiet window after it has passed
                if (tmr_expired)
                begin
                    state_d        = ACR_ST_RD_LOW;
                    pins_d.read_n  = 1'b0;
                    tmr_load       = 1'b1;
                    tmr_value      = `ACR_LOAD(`ACR_T_RD_LOW_NS);
                end
            end
            ACR_ST_RD_LOW:
            begin
                if (tmr_expired)
                begin
                    // Synchronised data lags the pins by two cycles, still well inside
                    // the strobe after the device's access delay
                    state_d       = ACR_ST_RD_HIGH;
                    pins_d.read_n = 1'b1;
                    acc_d         = merged;
                    tmr_load      = 1'b1;
                    tmr_value     = `ACR_LOAD(`ACR_T_RD_HIGH_NS);
                    if (last_read)
                    begin
                        result_d = '{valid: 1'b1, data: merged};
                    end
                    else if (lane_moves)
                    begin
                        pins_d.lane_select = next_lane;
                        tmr_value          = `ACR_LOAD(`ACR_RD_GAP_NS);
                    end
                end
            end
            ACR_ST_RD_HIGH:
            begin
                if (tmr_expired)
                begin
                    if (last_read)
                    begin
                        state_d         = ACR_ST_RECOVER;
                        pins_d.select_n = 1'b1;
                        tmr_load        = 1'b1;
                        tmr_value       = `ACR_LOAD(`ACR_RECOVER_NS);
                    end
                    else
                    begin
                        state_d       = ACR_ST_RD_LOW;
                        idx_d         = 2'(idx_q + 2'h1);
                        pins_d.read_n = 1'b0;
                        tmr_load      = 1'b1;
                        tmr_value     = `ACR_LOAD(`ACR_T_RD_LOW_NS);
                    end
                end
            end
            ACR_ST_RECOVER:
            begin
                if (tmr_expired)
                begin
                    state_d = ACR_ST_IDLE;
                end
            end
            default:
            begin
                state_d = ACR_ST_IDLE;
                pins_d  = '{conversion_trigger_n: 1'b1, select_n: 1'b1, read_n: 1'b1,
                            lane_select: `ACR_LANE_UPPER, word_width_select: `ACR_WIDTH_FULL};
            end
        endcase
    end

    // ============================================================
    // State registers
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_q  <= ACR_ST_IDLE;
            mode_q   <= ACR_MODE_FULL;
            idx_q    <= 2'h0;
            acc_q    <= '0;
            fault_q  <= 1'b0;
            result_q <= '0;
            pins_q   <= '{conversion_trigger_n: 1'b1, select_n: 1'b1, read_n: 1'b1,
                          lane_select: `ACR_LANE_UPPER, word_width_select: `ACR_WIDTH_FULL};
        end
        else
        begin
            state_q  <= state_d;
            mode_q   <= mode_d;
            idx_q    <= idx_d;
            acc_q    <= acc_d;
            fault_q  <= fault_d;
            result_q <= result_d;
            pins_q   <= pins_d;
        end
    end

    // ============================================================
    // Outputs
    assign pins       = pins_q;
    assign result     = result_q;
    assign conv_fault = fault_q;

endmodule : acr_host_ctrl

`default_nettype wire

// file: dv/acr_host_ctrl_asserts.sv
// Pin timing checks for the converter readout host controller
`include "acr_defs.svh"
`default_nettype none

module acr_host_ctrl_asserts
    import acr_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire logic                   start_valid,
    input wire acr_mode_e              start_mode,
    input wire logic                   start_ready,
    input wire acr_result_s            result,
    input wire logic                   conv_fault,
    input wire acr_pins_s              pins,
    input wire logic                   busy,
    input wire logic [`ACR_DATA_W-1:0] data_bus
);
    timeunit 1ns;
    timeprecision 100ps;

    // ============================================================
    // Run lengths: busy low, and read strobe high since its last rise
    logic [6:0] lo_q;
    logic [6:0] lo_d;
    logic [4:0] rd_q;
    logic [4:0] rd_d;
    // Read strobe low run, and cycles since lane select last moved
    logic [3:0] rl_q;
    logic [3:0] rl_d;
    logic [3:0] ls_q;
    logic [3:0] ls_d;
    logic       lane_last_q;
    assign rl_d = pins.read_n ? 4'h0 : (rl_q == 4'hF ? rl_q : rl_q + 4'h1);
    assign ls_d = (pins.lane_select != lane_last_q) ? 4'h0
                : (ls_q == 4'hF ? ls_q : ls_q + 4'h1);
    always_ff @(posedge clk) rl_q <= reset_n ? rl_d : 4'h0;
    always_ff @(posedge clk) ls_q <= reset_n ? ls_d : 4'hF;
    always_ff @(posedge clk) lane_last_q <= pins.lane_select;
    assign lo_d = busy ? 7'h00 : (lo_q == 7'h50 ? lo_q : lo_q + 7'h01);
    assign rd_d = !pins.read_n ? 5'h00 : (rd_q == 5'h1F ? rd_q : rd_q + 5'h01);
    always_ff @(posedge clk) lo_q <= reset_n ? lo_d : 7'h00;
    always_ff @(posedge clk) rd_q <= reset_n ? rd_d : 5'h1F;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ============================================================
    // Properties
    property p_acq;
        $fell(pins.conversion_trigger_n) |-> lo_q == 7'h50;
    endproperty
    a_acq: assert property (p_acq)
        else $error("trigger before acquisition time");
    property p_trig_low;
        $fell(pins.conversion_trigger_n) |-> !pins.conversion_trigger_n [*8];
    endproperty
    a_trig_low: assert property (p_trig_low)
        else $error("trigger pulse too short");
    property p_cs_setup;
        $fell(pins.conversion_trigger_n) |-> $past(pins.select_n, 4) == 1'b0;
    endproperty
    a_cs_setup: assert property (p_cs_setup)
        else $error("select setup before trigger too short");
    property p_quiet;
        $fell(pins.conversion_trigger_n) |-> ($stable(pins.read_n)
            && $stable(pins.lane_select) && $stable(pins.word_width_select)) [*8];
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("bus activity right after trigger");
    property p_frame;
        !pins.read_n |-> !pins.select_n;
    endproperty
    a_frame: assert property (p_frame)
        else $error("read strobe outside select");
    property p_rd_low;
        $rose(pins.read_n) |-> rl_q >= 4'hA;
    endproperty
    a_rd_low: assert property (p_rd_low)
        else $error("read strobe too short");
    property p_cs_high;
        $rose(pins.select_n) |-> pins.select_n [*4];
    endproperty
    a_cs_high: assert property (p_cs_high)
        else $error("select high too short");
    property p_last_rd;
        $fell(pins.conversion_trigger_n) |-> rd_q >= 5'h19;
    endproperty
    a_last_rd: assert property (p_last_rd)
        else $error("trigger too soon after last read");
    property p_msb_wait;
        $fell(busy) |-> pins.read_n [*6];
    endproperty
    a_msb_wait: assert property (p_msb_wait)
        else $error("first read too soon after busy fell");
    property p_sel_setup;
        $fell(pins.read_n) |-> pins.lane_select == $past(pins.lane_select, 2)
            && pins.word_width_select == $past(pins.word_width_select, 2);
    endproperty
    a_sel_setup: assert property (p_sel_setup)
        else $error("select changed too close to read");
    property p_lane_space;
        $changed(pins.lane_select) |-> ls_q >= 4'h9;
    endproperty
    a_lane_space: assert property (p_lane_space)
        else $error("lane select toggled too fast");

endmodule : acr_host_ctrl_asserts

bind acr_host_ctrl acr_host_ctrl_asserts u_asserts
(
    .clk(clk), .reset_n(reset_n), .start_valid(start_valid), .start_mode(start_mode),
    .start_ready(start_ready), .result(result), .conv_fault(conv_fault), .pins(pins),
    .busy(busy), .data_bus(data_bus)
);

`default_nettype wire

// file: dv/acr_dev_model.sv
// Behavioural model of the sampling converter seen from its pins
`include "acr_defs.svh"
`default_nettype none

module acr_dev_model
    import acr_pkg::*;
(
    input  wire acr_pins_s              pins,
    input  wire logic [`ACR_DATA_W-1:0] sample,
    input  wire logic                   stuck,
    input  wire logic                   slow,
    output var logic                    busy,
    output var logic [`ACR_DATA_W-1:0]  data_bus
);
    timeunit 1ns;
    timeprecision 100ps;

    // ============================================================
    // Conversion; stuck models a part that never starts
    initial busy = 1'b0;
    always @(negedge pins.conversion_trigger_n)
        if (!stuck)
        begin
            // Off the clock edge so the synchroniser sees no race
            #21 busy = 1'b1;
            #(slow ? 1500 : 300) busy = 1'b0;
        end

    // ============================================================
    // Read data
    wire logic                   drive;
    wire logic [`ACR_DATA_W-1:0] word;
    assign drive = !pins.select_n && !pins.read_n;
    assign word  = pins.word_width_select == `ACR_WIDTH_FULL ? sample
                 : pins.lane_select == `ACR_LANE_LOWER ? {16'h0000, sample[1:0]}
                 : {2'h0, sample[17:2]};
    // A released bus shows the inverse word so a stale value cannot match
    initial data_bus = 18'h15555;
    always @(drive or word)
        data_bus <= #16 (drive ? word : ~word);

endmodule : acr_dev_model

`default_nettype wire

// file: dv/tb_acr_host_ctrl.sv
// Self-checking bench for the converter readout host controller
`include "acr_defs.svh"
`default_nettype none

module tb_acr_host_ctrl
    import acr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                   clk;
    logic                   reset_n;
    logic                   start_valid;
    logic                   start_ready;
    logic                   conv_fault;
    logic                   busy;
    logic                   stuck;
    logic                   slow;
    acr_mode_e              start_mode;
    acr_result_s            result;
    acr_pins_s              pins;
    logic [`ACR_DATA_W-1:0] data_bus;
    logic [`ACR_DATA_W-1:0] sample;
    int                     fail_count;
    int                     cmp_count;

    acr_host_ctrl dut
    (
        .clk(clk), .reset_n(reset_n), .start_valid(start_valid),
        .start_mode(start_mode), .start_ready(start_ready), .result(result),
        .conv_fault(conv_fault), .pins(pins), .busy(busy), .data_bus(data_bus)
    );

    acr_dev_model u_dev
    (
        .pins(pins), .sample(sample), .stuck(stuck), .slow(slow),
        .busy(busy), .data_bus(data_bus)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ============================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    // One request; waits for the result or the fault pulse
    task automatic run(input acr_mode_e m, input logic [17:0] s, input logic flt,
                       input logic sl);
        int n;
        @(negedge clk);
        start_mode = m;
        sample = s;
        stuck = flt;
        slow = sl;
        start_valid = 1'b1;
        n = 0;
        while (start_ready !== 1'b1 && n < 500)
        begin
            @(negedge clk);
            n++;
        end
        check(start_ready, 1'b1);
        @(negedge clk);
        start_valid = 1'b0;
        check(start_ready, 1'b0);
        n = 0;
        while (result.valid !== 1'b1 && conv_fault !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        check(conv_fault, flt);
        check(result.valid, !flt);
        if (!flt)
            check(result.data, s);
        @(negedge clk);
        check(result.valid, 1'b0);
        check(conv_fault, 1'b0);
    endtask : run

    // ============================================================
    // Scenarios
    task automatic t_reset();
        check(pins, 5'h1D);
        check(start_ready, 1'b0);
        check(result, 19'h00000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_full();
        run(ACR_MODE_FULL, 18'h2A5C3, 1'b0, 1'b0);
        $display("test full done");
    endtask : t_full

    task automatic t_half_slow();
        run(ACR_MODE_HALF, 18'h1F0A6, 1'b0, 1'b1);
        $display("test half slow done");
    endtask : t_half_slow

    // Back to back with boundary words, the second limited by acquisition
    task automatic t_back();
        run(ACR_MODE_FULL, 18'h3FFFF, 1'b0, 1'b1);
        run(ACR_MODE_HALF, 18'h00001, 1'b0, 1'b0);
        $display("test back to back done");
    endtask : t_back

    task automatic t_fault();
        run(ACR_MODE_FULL, 18'h12345, 1'b1, 1'b0);
        check(pins.select_n, 1'b1);
        run(ACR_MODE_HALF, 18'h20003, 1'b0, 1'b0);
        $display("test fault recovery done");
    endtask : t_fault

    // ============================================================
    // Main sequence and watchdog
    initial
    begin
        fail_count = 0;
        cmp_count = 0;
        reset_n = 1'b0;
        start_valid = 1'b0;
        start_mode = ACR_MODE_FULL;
        sample = 18'h00000;
        stuck = 1'b0;
        slow = 1'b0;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        t_reset();
        t_full();
        t_half_slow();
        t_back();
        t_fault();
        conclude();
    end

    // The tests need about 1300 cycles; allow about thirty times that
    initial
    begin
        #200us;
        fail_count++;
        conclude();
    end

endmodule : tb_acr_host_ctrl

`default_nettype wire
